/* File: iod_addr_map.sv */
// address legality and i/o-to-data translation for one core access
`timescale 1ns/1ns
`default_nettype none
`include "iod_defs.svh"
module iod_addr_map
	import iod_pkg::*;
(
	input wire iod_op_type op,
	input wire logic [15:0] addr,
	output logic legal,
	output logic [7:0] dataAddr
);
	// decode per access kind
	always_comb begin
		legal = 1'b0;
		dataAddr = 8'h00;
		unique case (op)
			// dedicated in/out: i/o numbers 0x00..0x3f, shifted by 0x20
			IOD_OP_IN, IOD_OP_OUT: begin
				legal = (addr <= `IOD_IO_LAST);
				dataAddr = addr[7:0] + `IOD_DATA_OFFSET;
			end
			// bit ops: only the low 32 i/o numbers
			IOD_OP_SETB, IOD_OP_CLRB, IOD_OP_SKIPSET, IOD_OP_SKIPCLR: begin
				legal = (addr <= `IOD_BIT_LAST);
				dataAddr = addr[7:0] + `IOD_DATA_OFFSET;
			end
			// load/store: data addresses 0x20..0xff incl. extended space
			IOD_OP_LOAD, IOD_OP_STORE: begin
				legal = (addr >= `IOD_DATA_FIRST) && (addr <= `IOD_EXT_LAST);
				dataAddr = addr[7:0];
			end
		endcase
	end
endmodule : iod_addr_map
`default_nettype wire

/* File: iod_core_model.sv */
// core-side request driver for the i/o space decoder
`timescale 1ns/1ns
`default_nettype none
module iod_core_model
	import iod_pkg::*;
(
	input wire logic clk,
	output logic reqValid,
	output iod_op_type reqOp,
	output logic [15:0] reqAddr,
	output logic [2:0] reqBit,
	output logic [7:0] reqWdata
);
	// idle lines at time zero
	initial begin
		reqValid = 1'b0;
		reqOp = IOD_OP_IN;
		reqAddr = 16'h0000;
		reqBit = 3'h0;
		reqWdata = 8'h00;
	end
	// one access, held across the taking edge
	task acc(input iod_op_type o, input logic [15:0] a,
		input logic [2:0] b, input logic [7:0] d);
		@(negedge clk);
		reqValid = 1'b1;
		reqOp = o;
		reqAddr = a;
		reqBit = b;
		reqWdata = d;
		@(negedge clk);
		reqValid = 1'b0;
		// released address and data lines show junk, not the old value
		reqAddr = ~a;
		reqWdata = ~d;
	endtask : acc
endmodule : iod_core_model
`default_nettype wire

/* File: iod_defs.svh */
// address map constants for the peripheral i/o space decoder
`ifndef IOD_DEFS_SVH
`define IOD_DEFS_SVH
// last i/o number reachable by dedicated in/out ops
`define IOD_IO_LAST 16'h003F
// number of i/o locations the opcode can encode
`define IOD_IO_COUNT 16'h0040
// last i/o number reachable by single-bit ops
`define IOD_BIT_LAST 16'h001F
// data-space offset of i/o number zero
`define IOD_DATA_OFFSET 8'h20
// first data address of the extended i/o space
`define IOD_EXT_FIRST 16'h0060
// last data address of the peripheral space
`define IOD_EXT_LAST 16'h00FF
// first data address of the peripheral space
`define IOD_DATA_FIRST 16'h0020
// reset value of every peripheral register
`define IOD_REG_RESET 8'h00
`endif

/* File: iod_io_space.sv */
// peripheral i/o register space with access decoding for the core
// Functional notes
// - bit set/clear only on i/o 0x00..0x1F
// - bit test samples any bit, low range
// - status flags clear on writing one
// - bit ops touch only the addressed bit
// - in/out ops use i/o numbers 0x00..0x3F
// - data-space address is i/o number plus 0x20
// - only 64 locations reachable by in/out
// - extended 0x60..0xFF only via load/store
`timescale 1ns/1ns
`default_nettype none
`include "iod_defs.svh"
module iod_io_space
	import iod_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic reqValid,
	input wire iod_op_type reqOp,
	input wire logic [15:0] reqAddr,
	input wire logic [2:0] reqBit,
	input wire logic [7:0] reqWdata,
	input wire logic hwSetValid,
	input wire logic [7:0] hwSetAddr,
	input wire logic [7:0] hwSetMask,
	output logic rspValid_r,
	output logic rspErr_r,
	output logic [7:0] rspData_r,
	output logic rspBit_r
);
	// register storage indexed by data address
	logic [7:0] regs_r [32:255];
	logic [7:0] regsNxt [32:255];
	logic rspValid_nxt;
	logic rspErr_nxt;
	logic [7:0] rspData_nxt;
	logic rspBit_nxt;
	// decoded access
	logic legal;
	logic [7:0] dataAddr;
	logic acc;
	logic rsv;
	logic [7:0] cur;
	logic [7:0] mask;
	logic [7:0] bitSel;
	logic wrEn;
	logic [7:0] wrVal;
	logic testSample;

	// flags that clear on a written one
	function automatic logic [7:0] w1cMask(input logic [7:0] a);
		case (a)
			8'h36: w1cMask = 8'h27;
			8'h37: w1cMask = 8'h07;
			8'h3B: w1cMask = 8'h07;
			8'h3C: w1cMask = 8'h03;
			default: w1cMask = 8'h00;
		endcase
	endfunction : w1cMask

	// unimplemented locations in the map
	function automatic logic isReserved(input logic [7:0] a);
		case (a)
			8'h38, 8'h39, 8'h3A, 8'h49, 8'h4F: isReserved = 1'b1;
			8'h51, 8'h52, 8'h56: isReserved = 1'b1;
			default: isReserved = 1'b0;
		endcase
	endfunction : isReserved

	// address legality and translation
	iod_addr_map iod_addr_map_i (
		.op(reqOp),
		.addr(reqAddr),
		.legal(legal),
		.dataAddr(dataAddr)
	);

	// access evaluation and next state of storage
	always_comb begin
		acc = reqValid && legal;
		rsv = isReserved(dataAddr);
		cur = rsv ? 8'h00 : regs_r[dataAddr];
		mask = w1cMask(dataAddr);
		bitSel = 8'h01 << reqBit;
		testSample = |(cur & bitSel);
		wrEn = 1'b0;
		wrVal = cur;
		unique case (reqOp)
			// full-byte write: ones clear flags, zeros leave them
			IOD_OP_OUT, IOD_OP_STORE: begin
				wrEn = acc && !rsv;
				wrVal = (reqWdata & ~mask) | (cur & mask & ~reqWdata);
			end
			// set on a flag bit clears just that flag
			IOD_OP_SETB: begin
				wrEn = acc && !rsv;
				wrVal = |(mask & bitSel) ? (cur & ~bitSel) : (cur | bitSel);
			end
			// clear on a flag bit writes zero, which leaves it
			IOD_OP_CLRB: begin
				wrEn = acc && !rsv;
				wrVal = |(mask & bitSel) ? cur : (cur & ~bitSel);
			end
			// reads and tests change nothing
			default: begin
				wrEn = 1'b0;
			end
		endcase
		regsNxt = regs_r;
		if (wrEn) begin
			regsNxt[dataAddr] = wrVal;
		end
		// hardware flag set wins over a same-cycle clear
		if (hwSetValid && hwSetAddr >= `IOD_DATA_OFFSET && !isReserved(hwSetAddr)) begin
			regsNxt[hwSetAddr] = regsNxt[hwSetAddr] | hwSetMask;
		end
	end

	// response next values
	always_comb begin
		rspValid_nxt = reqValid;
		rspErr_nxt = reqValid && !legal;
		rspData_nxt = 8'h00;
		rspBit_nxt = 1'b0;
		if (acc) begin
			unique case (reqOp)
				// byte reads
				IOD_OP_IN, IOD_OP_LOAD: begin
					rspData_nxt = cur;
				end
				// skip decision for bit tests
				IOD_OP_SKIPSET: begin
					rspBit_nxt = testSample;
				end
				IOD_OP_SKIPCLR: begin
					rspBit_nxt = !testSample;
				end
				default: begin
					rspData_nxt = 8'h00;
				end
			endcase
		end
	end

	// storage registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 32; i < 256; i++) begin
				regs_r[i] <= `IOD_REG_RESET;
			end
		end else begin
			regs_r <= regsNxt;
		end
	end

	// response registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rspValid_r <= 1'b0;
			rspErr_r <= 1'b0;
			rspData_r <= 8'h00;
			rspBit_r <= 1'b0;
		end else begin
			rspValid_r <= rspValid_nxt;
			rspErr_r <= rspErr_nxt;
			rspData_r <= rspData_nxt;
			rspBit_r <= rspBit_nxt;
		end
	end

	// a bit op request in the low range
	sequence seqBitReq;
		reqValid && (reqOp == IOD_OP_SETB || reqOp == IOD_OP_CLRB)
			&& reqAddr <= `IOD_BIT_LAST && !hwSetValid;
	endsequence

	// a bit op beyond 0x1f
	sequence seqBitFar;
		reqValid && reqOp inside {IOD_OP_SETB, IOD_OP_CLRB,
			IOD_OP_SKIPSET, IOD_OP_SKIPCLR} && reqAddr > `IOD_BIT_LAST;
	endsequence

	chk_bit_range_refused: assert property (
		@(posedge clk) disable iff (!rstn)
		seqBitFar |=> rspValid_r && rspErr_r)
		else $error("bit op beyond low range not refused");

	chk_bit_test_sample: assert property (
		@(posedge clk) disable iff (!rstn)
		reqValid && reqOp == IOD_OP_SKIPSET && reqAddr <= `IOD_BIT_LAST
		|=> rspBit_r == $past(regs_r[{3'b001, reqAddr[4:0]}][reqBit]))
		else $error("bit test result wrong");

	chk_w1c_write_one: assert property (
		@(posedge clk) disable iff (!rstn)
		reqValid && reqOp == IOD_OP_OUT && legal && !hwSetValid
		|=> (regs_r[$past(dataAddr)] & $past(mask & reqWdata)) == 8'h00)
		else $error("flag not cleared by written one");

	// a hardware flag set at 0x20 or above on an unreserved location always lands, even against a clear
	chk_hw_set_wins: assert property (
		@(posedge clk) disable iff (!rstn)
		hwSetValid && hwSetAddr >= `IOD_DATA_OFFSET && !isReserved(hwSetAddr)
		|=> (regs_r[$past(hwSetAddr)] & $past(hwSetMask)) == $past(hwSetMask))
		else $error("hardware flag set lost");

	chk_bit_only_target: assert property (
		@(posedge clk) disable iff (!rstn)
		seqBitReq |=> (regs_r[$past(dataAddr)] & ~$past(bitSel))
			== ($past(cur) & ~$past(bitSel)))
		else $error("bit op disturbed other bits");

	chk_io_range_ok: assert property (
		@(posedge clk) disable iff (!rstn)
		reqValid && reqOp == IOD_OP_IN && reqAddr <= `IOD_IO_LAST
		|=> rspValid_r && !rspErr_r)
		else $error("in op within range refused");

	chk_io_offset_map: assert property (
		@(posedge clk) disable iff (!rstn)
		reqValid && reqOp == IOD_OP_OUT && reqAddr <= `IOD_IO_LAST
			&& !hwSetValid && !isReserved(reqAddr[7:0] + 8'h20)
			&& w1cMask(reqAddr[7:0] + 8'h20) == 8'h00
		|=> regs_r[$past(reqAddr[7:0]) + 8'h20] == $past(reqWdata))
		else $error("out op missed offset location");

	chk_io_count_limit: assert property (
		@(posedge clk) disable iff (!rstn)
		reqValid && (reqOp == IOD_OP_IN || reqOp == IOD_OP_OUT)
			&& reqAddr >= `IOD_IO_COUNT
		|=> rspValid_r && rspErr_r)
		else $error("in/out beyond 64 locations accepted");

	chk_ext_loadstore: assert property (
		@(posedge clk) disable iff (!rstn)
		reqValid && reqOp == IOD_OP_LOAD && reqAddr >= `IOD_EXT_FIRST
			&& reqAddr <= `IOD_EXT_LAST
		|=> !rspErr_r && rspValid_r)
		else $error("extended load refused");

	chk_reserved_zero: assert property (
		@(posedge clk) disable iff (!rstn)
		reqValid && reqOp == IOD_OP_LOAD && legal && isReserved(dataAddr)
		|=> rspData_r == 8'h00)
		else $error("reserved location read nonzero");
endmodule : iod_io_space
`default_nettype wire

/* File: iod_pkg.sv */
// types shared by the i/o space decoder modules
package iod_pkg;
	// access kinds issued by the core
	typedef enum logic [2:0] {
		IOD_OP_IN = 3'h0,
		IOD_OP_OUT = 3'h1,
		IOD_OP_SETB = 3'h2,
		IOD_OP_CLRB = 3'h3,
		IOD_OP_SKIPSET = 3'h4,
		IOD_OP_SKIPCLR = 3'h5,
		IOD_OP_LOAD = 3'h6,
		IOD_OP_STORE = 3'h7
	} iod_op_type;
endpackage : iod_pkg

/* File: test_io_space_access_decoder.sv */
// self-checking bench for the i/o space decoder
`timescale 1ns/1ns
`default_nettype none
module test_io_space_access_decoder
	import iod_pkg::*;
;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic reqValid, rspValid_r, rspErr_r, rspBit_r;
	iod_op_type reqOp;
	logic [15:0] reqAddr;
	logic [2:0] reqBit;
	logic [7:0] reqWdata, rspData_r;
	logic hwSetValid = 1'b0;
	logic [7:0] hwSetAddr = 8'h00;
	logic [7:0] hwSetMask = 8'h00;
	int error_cnt = 0;
	int compares = 0;
	// 40 ns core clock
	always #20 clk = ~clk;
	iod_core_model iod_core_model_i (.clk(clk), .reqValid(reqValid),
		.reqOp(reqOp), .reqAddr(reqAddr), .reqBit(reqBit),
		.reqWdata(reqWdata));
	iod_io_space iod_io_space_i (.clk(clk), .rstn(rstn),
		.reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
		.reqBit(reqBit), .reqWdata(reqWdata), .hwSetValid(hwSetValid),
		.hwSetAddr(hwSetAddr), .hwSetMask(hwSetMask),
		.rspValid_r(rspValid_r), .rspErr_r(rspErr_r),
		.rspData_r(rspData_r), .rspBit_r(rspBit_r));
	// verdict and end of run
	task summarize();
		if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : summarize
	// one comparison
	task chk(input string n, input logic [7:0] x, input logic [7:0] g);
		compares++;
		if (g !== x) begin
			$display("CHECK FAILED %s exp %h got %h", n, x, g);
			error_cnt++;
		end
	endtask : chk
	// access plus check of the whole response
	task run(input iod_op_type o, input logic [15:0] a, input logic [2:0] b,
		input logic [7:0] d, input logic e, input logic [7:0] x,
		input logic k);
		iod_core_model_i.acc(o, a, b, d);
		chk("rspValid", 8'h01, {7'h00, rspValid_r});
		chk("rspErr", {7'h00, e}, {7'h00, rspErr_r});
		chk("rspData", x, rspData_r);
		chk("rspBit", {7'h00, k}, {7'h00, rspBit_r});
	endtask : run
	// i/o numbering, data offset, 64-location limit
	task t_map();
		run(IOD_OP_OUT, 16'h001E, 3'h0, 8'h5A, 0, 8'h00, 0);
		run(IOD_OP_LOAD, 16'h003E, 3'h0, 8'h00, 0, 8'h5A, 0);
		run(IOD_OP_STORE, 16'h004A, 3'h0, 8'hC3, 0, 8'h00, 0);
		run(IOD_OP_IN, 16'h002A, 3'h0, 8'h00, 0, 8'hC3, 0);
		run(IOD_OP_IN, 16'h003F, 3'h0, 8'h00, 0, 8'h00, 0);
		run(IOD_OP_IN, 16'h0040, 3'h0, 8'h00, 1, 8'h00, 0);
		run(IOD_OP_OUT, 16'h0040, 3'h0, 8'hFF, 1, 8'h00, 0);
	endtask : t_map
	// extended space by load/store only
	task t_ext();
		run(IOD_OP_STORE, 16'h00FF, 3'h0, 8'hA5, 0, 8'h00, 0);
		run(IOD_OP_LOAD, 16'h00FF, 3'h0, 8'h00, 0, 8'hA5, 0);
		run(IOD_OP_IN, 16'h0060, 3'h0, 8'h00, 1, 8'h00, 0);
		run(IOD_OP_LOAD, 16'h0100, 3'h0, 8'h00, 1, 8'h00, 0);
		run(IOD_OP_STORE, 16'h001F, 3'h0, 8'h11, 1, 8'h00, 0);
	endtask : t_ext
	// bit set, clear and test in the low range
	task t_bits();
		run(IOD_OP_SETB, 16'h001E, 3'h7, 8'h00, 0, 8'h00, 0);
		run(IOD_OP_CLRB, 16'h001E, 3'h1, 8'h00, 0, 8'h00, 0);
		run(IOD_OP_IN, 16'h001E, 3'h0, 8'h00, 0, 8'hD8, 0);
		run(IOD_OP_SKIPSET, 16'h001E, 3'h7, 8'h00, 0, 8'h00, 1);
		run(IOD_OP_SKIPCLR, 16'h001E, 3'h7, 8'h00, 0, 8'h00, 0);
		run(IOD_OP_SKIPCLR, 16'h001E, 3'h0, 8'h00, 0, 8'h00, 1);
		run(IOD_OP_SETB, 16'h001F, 3'h0, 8'h00, 0, 8'h00, 0);
		run(IOD_OP_LOAD, 16'h003F, 3'h0, 8'h00, 0, 8'h01, 0);
		run(IOD_OP_SETB, 16'h0020, 3'h0, 8'h00, 1, 8'h00, 0);
		run(IOD_OP_SKIPSET, 16'h0020, 3'h0, 8'h00, 1, 8'h00, 0);
	endtask : t_bits
	// write-one-to-clear flags under writes and bit ops
	task t_flags();
		@(negedge clk);
		hwSetValid = 1'b1;
		hwSetAddr = 8'h36;
		hwSetMask = 8'h27;
		@(negedge clk);
		hwSetValid = 1'b0;
		run(IOD_OP_LOAD, 16'h0036, 3'h0, 8'h00, 0, 8'h27, 0);
		run(IOD_OP_OUT, 16'h0016, 3'h0, 8'h01, 0, 8'h00, 0);
		run(IOD_OP_OUT, 16'h0016, 3'h0, 8'h00, 0, 8'h00, 0);
		run(IOD_OP_IN, 16'h0016, 3'h0, 8'h00, 0, 8'h26, 0);
		run(IOD_OP_SETB, 16'h0016, 3'h1, 8'h00, 0, 8'h00, 0);
		run(IOD_OP_CLRB, 16'h0016, 3'h2, 8'h00, 0, 8'h00, 0);
		run(IOD_OP_IN, 16'h0016, 3'h0, 8'h00, 0, 8'h24, 0);
		// write-one clear and hardware set on one flag in one cycle
		fork
			iod_core_model_i.acc(IOD_OP_OUT, 16'h0016, 3'h0, 8'h20);
			begin
				@(negedge clk);
				hwSetValid = 1'b1;
				hwSetMask = 8'h20;
				@(negedge clk);
				hwSetValid = 1'b0;
			end
		join
		run(IOD_OP_IN, 16'h0016, 3'h0, 8'h00, 0, 8'h24, 0);
	endtask : t_flags
	// mid-run reset clears storage and responses
	task t_reset();
		@(negedge clk);
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		chk("rspValid", 8'h00, {7'h00, rspValid_r});
		run(IOD_OP_IN, 16'h001E, 3'h0, 8'h00, 0, 8'h00, 0);
		run(IOD_OP_LOAD, 16'h00FF, 3'h0, 8'h00, 0, 8'h00, 0);
	endtask : t_reset
	// reserved places read zero and keep nothing
	task t_resv();
		run(IOD_OP_STORE, 16'h0038, 3'h0, 8'hFF, 0, 8'h00, 0);
		run(IOD_OP_LOAD, 16'h0038, 3'h0, 8'h00, 0, 8'h00, 0);
		run(IOD_OP_OUT, 16'h0019, 3'h0, 8'hFF, 0, 8'h00, 0);
		run(IOD_OP_IN, 16'h0019, 3'h0, 8'h00, 0, 8'h00, 0);
	endtask : t_resv
	// watchdog against a hang
	initial begin
		repeat (3000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		chk("rspValid", 8'h00, {7'h00, rspValid_r});
		t_map();
		t_ext();
		t_bits();
		t_flags();
		t_resv();
		t_reset();
		summarize();
	end
endmodule : test_io_space_access_decoder
`default_nettype wire
